// File: hw/rrs_pkg.sv
// Package for the return/rotate/sleep execution block.
// Assumes a single instruction clock domain inside the core.
package rrs_pkg;

  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PC_W    = 13;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned STACK_D = 8;
  localparam int unsigned SP_W    = 3;

  localparam logic [DATA_W-1:0] WATCHDOG_CLEAR  = 8'h00;
  localparam logic [DATA_W-1:0] PRESCALER_CLEAR = 8'h00;
  localparam logic [DATA_W-1:0] ACC_RESET       = 8'h00;
  localparam logic [PC_W-1:0]   PC_RESET        = 13'h0000;
  localparam logic [SP_W-1:0]   SP_RESET        = 3'h0;
  localparam logic              CARRY_RESET     = 1'b0;
  localparam logic              GIE_RESET       = 1'b0;
  localparam logic              PD_RESET        = 1'b1;
  localparam logic              TO_RESET        = 1'b1;

  // Destination select encoding for rotates
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Two instruction cycles for program-counter-reloading exits
  localparam int unsigned EXIT_CYCLES = 2;

  typedef enum logic [2:0] {
    RRS_OP_NONE = 3'h0,
    RRS_OP_IEXIT = 3'h1,
    RRS_OP_LEXIT = 3'h2,
    RRS_OP_SEXIT = 3'h3,
    RRS_OP_RLC   = 3'h4,
    RRS_OP_RRC   = 3'h5,
    RRS_OP_SLEEP = 3'h6,
    RRS_OP_CALL  = 3'h7
  } rrs_op_t;

  typedef struct packed {
    rrs_op_t             op;
    logic [DATA_W-1:0]   literal;
    logic [FADDR_W-1:0]  faddr;
    logic                dest;
    logic [PC_W-1:0]     call_ret;
  } rrs_instr_t;

  typedef struct packed {
    logic                we;
    logic [FADDR_W-1:0]  addr;
    logic [DATA_W-1:0]   data;
  } rrs_fwrite_t;

endpackage : rrs_pkg

// File: hw/rrs_rotate.sv
// Rotate-through-carry datapath for one file register value.
// Assumes the caller supplies the operand and carry of the same cycle.
`timescale 1ns/1ps
module rrs_rotate
  import rrs_pkg::*;
(
  // Operands
  input  wire logic              i_left,
  input  wire logic [DATA_W-1:0] i_val,
  input  wire logic              i_carry,
  // Results
  output logic      [DATA_W-1:0] o_val,
  output logic                   o_carry
);
  assign o_val   = i_left ? {i_val[DATA_W-2:0], i_carry}
                          : {i_carry, i_val[DATA_W-1:1]};
  assign o_carry = i_left ? i_val[DATA_W-1] : i_val[0];
endmodule : rrs_rotate

// File: hw/rrs_core.sv
// Decoder and datapath for exit, rotate and power-down instructions.
// Assumes one instruction offered per instruction cycle while ready;
// file register read data is valid in the cycle the instruction arrives.
`timescale 1ns/1ps
module rrs_core
  import rrs_pkg::*;
(
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  // Instruction in
  input  wire logic               i_valid,
  input  wire rrs_pkg::rrs_instr_t i_instr,
  input  wire logic [DATA_W-1:0]  i_fdata,
  // Wake-up source
  input  wire logic               i_wake,
  // Watchdog tick from the oscillator side
  input  wire logic               i_wdt_tick,
  // Core state out
  output logic                    o_ready,
  output logic                    o_flush,
  output rrs_pkg::rrs_fwrite_t    o_fwrite,
  output logic [PC_W-1:0]         o_pc,
  output logic [DATA_W-1:0]       o_acc,
  output logic                    o_carry,
  output logic                    o_global_irq_enable,
  output logic                    o_powerdown_flag,
  output logic                    o_timeout_flag,
  output logic [DATA_W-1:0]       o_watchdog_counter,
  output logic [DATA_W-1:0]       o_wdt_prescaler,
  output logic                    o_osc_run
);
  import rrs_pkg::*;

  typedef enum logic [2:0] {
    ST_EXEC  = 3'b001,
    ST_FLUSH = 3'b010,
    ST_SLEEP = 3'b100
  } rrs_state_t;

  rrs_state_t state_ff, nxt_state;

  logic [PC_W-1:0]   stack_mem [STACK_D];
  logic [SP_W-1:0]   sp_ff;
  logic [PC_W-1:0]   pc_ff;
  logic [DATA_W-1:0] acc_ff, wdt_ff, pre_ff;
  logic              carry_ff, gie_ff, pd_ff, to_ff;
  logic              ready_ff, flush_ff;
  logic              osc_ff;
  rrs_fwrite_t       fw_ff;

  function automatic logic [SP_W-1:0] sp_dec(input logic [SP_W-1:0] sp);
    sp_dec = sp - SP_W'(1);
  endfunction : sp_dec

  // Decode
  wire              take      = i_valid && (state_ff == ST_EXEC);
  wire              is_iexit  = take && (i_instr.op == RRS_OP_IEXIT);
  wire              is_lexit  = take && (i_instr.op == RRS_OP_LEXIT);
  wire              is_sexit  = take && (i_instr.op == RRS_OP_SEXIT);
  wire              is_rot    = take && ((i_instr.op == RRS_OP_RLC) ||
                                          (i_instr.op == RRS_OP_RRC));
  wire              is_sleep  = take && (i_instr.op == RRS_OP_SLEEP);
  wire              is_call   = take && (i_instr.op == RRS_OP_CALL);
  wire              is_exit   = is_iexit || is_lexit || is_sexit;
  wire [SP_W-1:0]   sp_pop    = sp_dec(sp_ff);
  // Stack head is the last pushed slot; the pop is a wrap like a ring
  wire [PC_W-1:0]   stack_head_entry = stack_mem[sp_pop];
  wire [DATA_W-1:0] rot_val;
  wire              rot_carry;
  wire              rot_to_acc  = is_rot && (i_instr.dest == DEST_ACC);
  wire              rot_to_file = is_rot && (i_instr.dest == DEST_FILE);
  wire              rot_left    = (i_instr.op == RRS_OP_RLC);
  // Watchdog halts with the oscillator, so ticks only count while awake
  wire              wdt_count   = i_wdt_tick && (state_ff != ST_SLEEP);
  wire              pre_wrap    = (pre_ff == '1);

  // Shared rotator; direction picked per instruction
  rrs_rotate u_rot (
    .i_left  (rot_left),
    .i_val   (i_fdata),
    .i_carry (carry_ff),
    .o_val   (rot_val),
    .o_carry (rot_carry)
  );

  // One flushed word after an exit; sleep waits for a wake level
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_EXEC: begin
        if (is_exit)
          nxt_state = ST_FLUSH;
        else if (is_sleep)
          nxt_state = ST_SLEEP;
      end
      ST_FLUSH: nxt_state = ST_EXEC;
      ST_SLEEP: begin
        if (i_wake)
          nxt_state = ST_EXEC;
      end
      default:  nxt_state = ST_EXEC;
    endcase
  end

  // Ready comes from the next state, so it changes with the state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_EXEC;
      ready_ff <= 1'b1;
      flush_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= (nxt_state == ST_EXEC);
      flush_ff <= is_exit;
    end
  end

  // Own flop for the oscillator gate, so no logic glitch reaches it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_ff <= 1'b1;
    end else begin
      osc_ff <= (nxt_state != ST_SLEEP);
    end
  end

  // Stack storage holds no control state, so it needs no reset
  // A ninth push without a pop overwrites the oldest return slot
  always_ff @(posedge i_clk) begin
    if (is_call)
      stack_mem[sp_ff] <= i_instr.call_ret;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp_ff <= SP_RESET;
      pc_ff <= PC_RESET;
    end else if (is_exit) begin
      sp_ff <= sp_pop;
      pc_ff <= stack_head_entry;
    end else if (is_call) begin
      sp_ff <= sp_ff + SP_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_ff   <= ACC_RESET;
      carry_ff <= CARRY_RESET;
      gie_ff   <= GIE_RESET;
    end else begin
      // Exits leave carry alone; only a rotate writes it
      if (is_lexit)
        acc_ff <= i_instr.literal;
      else if (rot_to_acc)
        acc_ff <= rot_val;
      if (is_rot)
        carry_ff <= rot_carry;
      if (is_iexit)
        gie_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fw_ff <= '0;
    end else begin
      // Address and data ride along every cycle; only we marks a write
      fw_ff.we   <= rot_to_file;
      fw_ff.addr <= i_instr.faddr;
      fw_ff.data <= rot_val;
    end
  end

  // Sleep wins over a tick in the same cycle, so the clear always lands
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdt_ff <= WATCHDOG_CLEAR;
      pre_ff <= PRESCALER_CLEAR;
      pd_ff  <= PD_RESET;
      to_ff  <= TO_RESET;
    end else if (is_sleep) begin
      wdt_ff <= WATCHDOG_CLEAR;
      pre_ff <= PRESCALER_CLEAR;
      pd_ff  <= 1'b0;
      to_ff  <= 1'b1;
    end else if (wdt_count) begin
      pre_ff <= pre_ff + DATA_W'(1);
      if (pre_wrap)
        wdt_ff <= wdt_ff + DATA_W'(1);
    end
  end

  // Every output is a flop copy; nothing combines on the way out
  assign o_ready             = ready_ff;
  assign o_flush             = flush_ff;
  assign o_fwrite            = fw_ff;
  assign o_pc                = pc_ff;
  assign o_acc               = acc_ff;
  assign o_carry             = carry_ff;
  assign o_global_irq_enable = gie_ff;
  assign o_powerdown_flag    = pd_ff;
  assign o_timeout_flag      = to_ff;
  assign o_watchdog_counter  = wdt_ff;
  assign o_wdt_prescaler     = pre_ff;
  assign o_osc_run           = osc_ff;

endmodule : rrs_core

// File: tb/rrs_core_sva.sv
// Checker for the exit, rotate and sleep behaviour of rrs_core.
// Sees only the core's ports; bound below.
`timescale 1ns/1ps
module rrs_core_sva
  import rrs_pkg::*;
(
  // Clock, reset, instruction
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_valid,
  input wire rrs_instr_t  i_instr,
  input wire logic [7:0]  i_fdata,
  input wire logic        i_wake,
  // Core state
  input wire logic        o_ready,
  input wire logic        o_flush,
  input wire rrs_fwrite_t o_fwrite,
  input wire logic [7:0]  o_acc,
  input wire logic        o_carry,
  input wire logic        o_global_irq_enable,
  input wire logic        o_powerdown_flag,
  input wire logic        o_timeout_flag,
  input wire logic [7:0]  o_watchdog_counter,
  input wire logic [7:0]  o_wdt_prescaler,
  input wire logic        o_osc_run
);
  wire     tk = i_valid & o_ready;
  rrs_op_t op;
  assign op = i_instr.op;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_iexit_gie_flush: assert property (
    tk && op == RRS_OP_IEXIT |=> o_global_irq_enable && o_flush && !o_ready)
    else $error("interrupt exit result wrong");
  a_lexit_acc: assert property (
    tk && op == RRS_OP_LEXIT |=> o_acc == $past(i_instr.literal))
    else $error("literal exit accumulator wrong");
  a_lexit_two_cyc: assert property (
    tk && op == RRS_OP_LEXIT |=> !o_ready ##1 o_ready)
    else $error("literal exit length wrong");
  a_sexit_flush: assert property (
    tk && op == RRS_OP_SEXIT |=> o_flush && !o_ready && $stable(o_carry))
    else $error("subroutine exit wrong");
  a_rlc_carry: assert property (
    tk && op == RRS_OP_RLC |=> o_carry == $past(i_fdata[7]))
    else $error("left rotate carry wrong");
  a_rrc_carry: assert property (
    tk && op == RRS_OP_RRC |=> o_carry == $past(i_fdata[0]))
    else $error("right rotate carry wrong");
  a_rot_dest_sel: assert property (
    tk && (op == RRS_OP_RLC || op == RRS_OP_RRC)
    |=> o_fwrite.we == $past(i_instr.dest))
    else $error("rotate destination wrong");
  a_sleep_wdt_clr: assert property (
    tk && op == RRS_OP_SLEEP |=> o_watchdog_counter == 8'h00
    && o_wdt_prescaler == 8'h00) else $error("watchdog not cleared");
  a_sleep_flags: assert property (
    tk && op == RRS_OP_SLEEP |=> !o_powerdown_flag && o_timeout_flag)
    else $error("sleep status flags wrong");
  a_sleep_halt: assert property (
    tk && op == RRS_OP_SLEEP |=> (!o_osc_run && !o_ready)
    ##1 ($past(i_wake) || (!o_osc_run && !o_ready)))
    else $error("core did not halt");
  a_wake_resume: assert property (
    !o_osc_run && i_wake |=> o_ready && o_osc_run)
    else $error("core did not wake");
  c_sleep: cover property (tk && op == RRS_OP_SLEEP);
  c_sexit: cover property (tk && op == RRS_OP_SEXIT);
  c_fwrite: cover property (o_fwrite.we);
endmodule : rrs_core_sva

bind rrs_core rrs_core_sva u_sva (.*);

// File: tb/testbench.sv
// Self-checking bench for rrs_core: rotate table, exits, sleep, wake.
// Drives every core input itself on the falling edge of a 40 MHz clock.
`timescale 1ns/1ps
module testbench;
  import rrs_pkg::*;
  typedef struct packed {
    rrs_op_t    op;
    logic       dest;
    logic [7:0] fd;
    logic [7:0] res;
    logic       cy;
  } rrs_row_t;
  logic        i_clk = 0, i_rst_n = 0, i_valid = 0;
  logic        i_wake = 0, i_wdt_tick = 0;
  rrs_instr_t  i_instr = '0;
  logic [7:0]  i_fdata = '0;
  logic        o_ready, o_flush, o_carry, o_global_irq_enable;
  logic        o_powerdown_flag, o_timeout_flag, o_osc_run;
  rrs_fwrite_t o_fwrite;
  logic [12:0] o_pc;
  logic [7:0]  o_acc, o_watchdog_counter, o_wdt_prescaler;
  int          miscompares = 0, check_count = 0;
  // Carry chains from row to row, starting at 0 after reset
  rrs_row_t    rows [4] = '{'{RRS_OP_RLC, 1'b0, 8'h81, 8'h02, 1'b1},
    '{RRS_OP_RLC, 1'b1, 8'h00, 8'h01, 1'b0},
    '{RRS_OP_RRC, 1'b1, 8'h01, 8'h00, 1'b1},
    '{RRS_OP_RRC, 1'b0, 8'h03, 8'h81, 1'b1}};
  always #12.5 i_clk = ~i_clk;
  rrs_core DUT (.*);
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic issue(input rrs_op_t op, input logic [12:0] v,
                       input logic [7:0] fd, input logic d);
    int n;
    n = 0;
    // One idle edge first, so valid never drops and rises in one step
    @(negedge i_clk);
    while (o_ready !== 1'b1 && n < 8) begin
      @(negedge i_clk);
      n++;
    end
    if (o_ready !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
    i_instr = '{op, v[7:0], 7'h05, d, v};
    i_fdata = fd;
    i_valid = 1'b1;
    @(negedge i_clk);
    i_valid = 1'b0;
  endtask : issue
  initial begin
    repeat (3) @(negedge i_clk);
    chk(o_timeout_flag, 1'b1);
    i_rst_n = 1'b1;
    i_wdt_tick = 1'b1;
    foreach (rows[k]) begin
      issue(rows[k].op, '0, rows[k].fd, rows[k].dest);
      chk(rows[k].dest ? o_fwrite.data : o_acc, rows[k].res);
      chk(o_carry, rows[k].cy);
      chk(o_fwrite.we, rows[k].dest);
      chk(o_fwrite.addr, 7'h05);
    end
    i_wdt_tick = 1'b0;
    issue(RRS_OP_CALL, 13'h0abc, 8'h00, 1'b0);
    issue(RRS_OP_CALL, 13'h1234, 8'h00, 1'b0);
    issue(RRS_OP_CALL, 13'h0777, 8'h00, 1'b0);
    issue(RRS_OP_SEXIT, '0, 8'h00, 1'b0);
    chk(o_pc, 13'h0777);
    chk(o_flush, 1'b1);
    issue(RRS_OP_LEXIT, 13'h00ff, 8'h00, 1'b0);
    chk(o_acc, 8'hff);
    chk(o_pc, 13'h1234);
    chk(o_carry, 1'b1);
    chk(o_ready, 1'b0);
    @(negedge i_clk);
    chk(o_ready, 1'b1);
    issue(RRS_OP_IEXIT, '0, 8'h00, 1'b0);
    chk(o_pc, 13'h0abc);
    chk(o_global_irq_enable, 1'b1);
    chk(o_flush, 1'b1);
    i_wdt_tick = 1'b1;
    repeat (260) @(negedge i_clk);
    chk(o_watchdog_counter != 8'h00, 1'b1);
    issue(RRS_OP_SLEEP, '0, 8'h00, 1'b0);
    chk(o_watchdog_counter | o_wdt_prescaler, 8'h00);
    chk({o_powerdown_flag, o_timeout_flag, o_carry}, 3'h3);
    repeat (3) @(negedge i_clk);
    chk({o_osc_run, o_ready}, 2'h0);
    chk(o_wdt_prescaler, 8'h00);
    i_wdt_tick = 1'b0;
    i_wake = 1'b1;
    issue(RRS_OP_RLC, '0, 8'h80, 1'b0);
    chk(o_acc, 8'h01);
    i_rst_n = 1'b0;
    @(negedge i_clk);
    chk({o_ready, o_flush, o_fwrite.we, o_osc_run}, 4'h9);
    chk(o_pc, 13'h0000);
    chk({o_acc, o_carry, o_global_irq_enable}, 10'h000);
    chk({o_powerdown_flag, o_timeout_flag}, 2'h3);
    i_rst_n = 1'b1;
    issue(RRS_OP_RRC, '0, 8'h03, 1'b0);
    chk(o_acc, 8'h01);
    chk(o_carry, 1'b1);
    wrap_up();
  end
endmodule : testbench
